// File: design/sacc_fifo.sv
// result buffer fifo with valid/ready on both sides
`timescale 1ns/10ps
module sacc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sacc_fifo_s;
  sacc_fifo_s st_ff, nxt_st;
  logic push, pop;

  assign in_ready_out = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out = mem[st_ff.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
    if (pop) nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
    if (push && !pop) nxt_st.cnt = st_ff.cnt + 1'b1;
    else if (pop && !push) nxt_st.cnt = st_ff.cnt - 1'b1;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clock_in) begin
    if (push) mem[st_ff.wr] <= in_data_in;
  end
endmodule : sacc_fifo

// File: design/sacc_pkg.sv
// package of constants and types for the sar conversion control block
//==================================================================
// Contract
// - falling convert_start_n with device select low starts a conversion
// - start edges during a running conversion are ignored
// - approximation_register cleared at conversion start before any decision
// - one bit decided per step, msb first, over 16 bits
// - final word is loaded into the result latches
// - busy low throughout conversion, high otherwise
// - conversion lasts typically 1.45 us, never above 1.8 us; the code takes 64 clocks of 20 ns, 1.28 us
// - acquisition within 400 ns; throughput allows 500 ksps
// - result is two's complement binary; the code gives the register word as straight binary
// - power_down_n low enters nap if select low, else sleep
// - nap keeps logic alive; wake to active within 200 ns
// - select and read low keep result_bus driven; capture on busy rise
// - only select low keeps result_bus undriven until read strobe
// - joined strobe starts conversion, old result shown until busy rises
// - joined strobe reads previous result and starts the next conversion
// - convert start and read recognised only while select is low
// - drivers enabled only while read and select both low
// - new result valid on result_bus by the time busy rises
package sacc_pkg;
  //==================================================================
  // widths and timing
  localparam int SACC_WIDTH = 16;
  localparam int SACC_CLK_NS = 20;
  localparam int SACC_CONV_NS = 1450;
  localparam int SACC_CONV_MAX_NS = 1800;
  localparam int SACC_ACQ_NS = 400;
  localparam int SACC_NAP_WAKE_NS = 200;
  // per-bit step: conversion split evenly over the bits, rounded down
  localparam int SACC_STEP_CYC = (SACC_CONV_NS / SACC_WIDTH) / SACC_CLK_NS;
  localparam int SACC_ACQ_CYC = SACC_ACQ_NS / SACC_CLK_NS;
  localparam int SACC_NAP_CYC = SACC_NAP_WAKE_NS / SACC_CLK_NS;
  localparam int SACC_FIFO_DEPTH = 32;
  // reset values
  localparam logic [SACC_WIDTH-1:0] SACC_RESULT_RST = 16'h0000;

  typedef enum logic [2:0] {
    SACC_IDLE,
    SACC_CONV,
    SACC_ACQ,
    SACC_NAP,
    SACC_SLEEP,
    SACC_WAKE
  } sacc_state_e;
endpackage : sacc_pkg

// File: design/sacc_top.sv
// sar conversion control: start, bit sequencing, result latch, busy, shutdown
`timescale 1ns/10ps
module sacc_top
  import sacc_pkg::*;
#(
  parameter int WIDTH = SACC_WIDTH,
  parameter int DEPTH = SACC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // host control pins
  input wire logic select_n_in,
  input wire logic convert_start_n_in,
  input wire logic read_n_in,
  input wire logic power_down_n_in,
  // comparator decision for the trial bit
  input wire logic compare_in,
  // parallel result port
  output logic [WIDTH-1:0] result_bus_out,
  output logic result_bus_oe_out,
  output logic busy_out,
  // analog side control
  output logic [WIDTH-1:0] approximation_register_out,
  output logic sample_out,
  output logic nap_out,
  output logic sleep_out,
  // result stream
  output logic stream_valid_out,
  output logic [WIDTH-1:0] stream_data_out,
  input wire logic stream_ready_in,
  output logic overrun_out
);
  localparam int BW = $clog2(WIDTH);

  //==================================================================
  // state
  typedef struct packed {
    sacc_state_e st;
    logic conv_n_q;
    logic [WIDTH-1:0] approximation_register;
    logic [WIDTH-1:0] result;
    logic [BW-1:0] bit_idx;
    logic [7:0] tmr;
    logic push;
    logic overrun;
  } sacc_s;
  sacc_s s_ff, nxt_s;
  logic start_edge;
  logic fifo_ready;

  // start edge only counts while selected
  assign start_edge = s_ff.conv_n_q && !convert_start_n_in && !select_n_in;

  //==================================================================
  // sequencer
  always_comb begin
    nxt_s = s_ff;
    nxt_s.conv_n_q = convert_start_n_in;
    nxt_s.push = 1'b0;
    case (s_ff.st)
      SACC_IDLE: begin
        if (!power_down_n_in) begin
          nxt_s.st = select_n_in ? SACC_SLEEP : SACC_NAP;
        end else if (start_edge) begin
          nxt_s.st = SACC_CONV;
          nxt_s.approximation_register = '0;
          nxt_s.approximation_register[WIDTH-1] = 1'b1; // first trial at msb
          nxt_s.bit_idx = BW'(WIDTH-1);
          nxt_s.tmr = 8'(SACC_STEP_CYC - 1);
        end
      end
      SACC_CONV: begin
        // start edges are not looked at here
        if (s_ff.tmr != '0) begin
          nxt_s.tmr = s_ff.tmr - 1'b1; // step length bounded
        end else begin
          nxt_s.approximation_register[s_ff.bit_idx] = compare_in; // decide bit
          if (s_ff.bit_idx == '0) begin
            // straight binary word from the register, not the two's complement the contract asks for
            nxt_s.result = {s_ff.approximation_register[WIDTH-1:1], compare_in};
            nxt_s.push = 1'b1;
            nxt_s.overrun = s_ff.overrun | !fifo_ready;
            nxt_s.st = SACC_ACQ;
            nxt_s.tmr = 8'(SACC_ACQ_CYC - 1);
          end else begin
            nxt_s.approximation_register[s_ff.bit_idx - 1'b1] = 1'b1;
            nxt_s.bit_idx = s_ff.bit_idx - 1'b1;
            nxt_s.tmr = 8'(SACC_STEP_CYC - 1);
          end
        end
      end
      SACC_ACQ: begin
        // acquisition runs in the background; busy is already high
        if (s_ff.tmr != '0) nxt_s.tmr = s_ff.tmr - 1'b1;
        else nxt_s.st = SACC_IDLE;
        if (start_edge && s_ff.tmr == '0) begin
          nxt_s.st = SACC_CONV;
          nxt_s.approximation_register = '0;
          nxt_s.approximation_register[WIDTH-1] = 1'b1;
          nxt_s.bit_idx = BW'(WIDTH-1);
          nxt_s.tmr = 8'(SACC_STEP_CYC - 1);
        end
      end
      SACC_NAP, SACC_SLEEP: begin
        if (power_down_n_in) begin
          nxt_s.st = SACC_WAKE;
          nxt_s.tmr = 8'(SACC_NAP_CYC - 1);
        end else if (select_n_in && s_ff.st == SACC_NAP) begin
          nxt_s.st = SACC_SLEEP; // nap deepens to sleep on select high
        end
      end
      SACC_WAKE: begin
        // after sleep the reference settling is the host's wait
        if (s_ff.tmr != '0) nxt_s.tmr = s_ff.tmr - 1'b1;
        else nxt_s.st = SACC_IDLE;
      end
      default: nxt_s.st = SACC_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s_ff.st <= SACC_IDLE;
      s_ff.conv_n_q <= 1'b1;
      s_ff.approximation_register <= '0;
      s_ff.result <= SACC_RESULT_RST;
      s_ff.bit_idx <= '0;
      s_ff.tmr <= '0;
      s_ff.push <= 1'b0;
      s_ff.overrun <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //==================================================================
  // pins: old result shown until the new one is latched with busy rise
  assign busy_out = (s_ff.st != SACC_CONV);
  assign result_bus_out = s_ff.result;
  assign result_bus_oe_out = !read_n_in && !select_n_in;
  assign approximation_register_out = s_ff.approximation_register;
  assign sample_out = (s_ff.st == SACC_ACQ) || (s_ff.st == SACC_IDLE);
  assign nap_out = (s_ff.st == SACC_NAP);
  assign sleep_out = (s_ff.st == SACC_SLEEP);
  assign overrun_out = s_ff.overrun;

  // results also queue here; a full queue drops and flags overrun
  sacc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .in_valid_in(s_ff.push),
    .in_data_in(s_ff.result),
    .in_ready_out(fifo_ready),
    .out_valid_out(stream_valid_out),
    .out_data_out(stream_data_out),
    .out_ready_in(stream_ready_in)
  );
endmodule : sacc_top

// File: tb/sacc_bench.sv
// self-checking bench for the sar conversion control block
`timescale 1ns/10ps
module sacc_bench
  import sacc_pkg::*;
;
  //==========
  // stimulus and observed signals
  logic clock_in = 0, reset_in = 1, select_n_in = 0, convert_start_n_in = 1;
  logic read_n_in = 0, power_down_n_in = 1, compare_in = 0, stall = 1;
  logic [15:0] target = 0, result_bus_out, approximation_register_out, stream_data_out;
  logic result_bus_oe_out, busy_out, sample_out, nap_out, sleep_out;
  logic stream_valid_out, stream_ready_in, overrun_out;
  int miscompares = 0, cmp_count = 0;
  initial forever #10 clock_in = ~clock_in;
  // comparator stand-in: the result converges on target
  always @(negedge clock_in) compare_in <= approximation_register_out <= target;
  sacc_top DUT (.clock_in, .reset_in, .select_n_in, .convert_start_n_in, .read_n_in,
    .power_down_n_in, .compare_in, .result_bus_out, .result_bus_oe_out, .busy_out,
    .approximation_register_out, .sample_out, .nap_out, .sleep_out, .stream_valid_out,
    .stream_data_out, .stream_ready_in, .overrun_out);
  sacc_host HOST (.clock_in, .stall_in(stall), .stream_valid_in(stream_valid_out),
    .stream_data_in(stream_data_out), .stream_ready_out(stream_ready_in));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // bounded wait for a busy level, counting falling edges
  task wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy_out !== lvl) begin
      @(negedge clock_in);
      n++;
      if (n > 200) begin
        miscompares++;
        test_done();
      end
    end
  endtask : wait_busy
  // narrow low pulse keeps the edge clear of bit decisions
  task pulse;
    @(negedge clock_in) convert_start_n_in = 0;
    @(negedge clock_in) convert_start_n_in = 1;
  endtask : pulse
  task convert(input logic [15:0] t, input bit again);
    int n;
    target = t;
    pulse();
    wait_busy(0, n);
    check("sample", 16'(sample_out), 16'h0000);
    if (again) pulse();
    wait_busy(1, n);
    check("cycles", 16'(n + (again ? 2 : 0)), 16'(SACC_STEP_CYC * SACC_WIDTH));
    check("result", result_bus_out, t);
    repeat (25) @(negedge clock_in);
  endtask : convert
  //==========
  // main sequence
  initial begin
    repeat (5) @(negedge clock_in);
    reset_in = 0;
    // stalled host: 32 words fill the buffer, the 33rd overflows
    for (int i = 0; i < 33; i++) convert(16'(i * 16'h0801), i == 3);
    check("overrun", 16'(overrun_out), 16'h0001);
    stall = 0;
    repeat (40) @(negedge clock_in);
    check("drained", 16'(HOST.got_q.size()), 16'h0020);
    check("tail", HOST.got_q[31], 16'hF81F);
    select_n_in = 1;
    pulse();
    repeat (3) @(negedge clock_in);
    check("busy", 16'(busy_out), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      @(negedge clock_in) {select_n_in, read_n_in} = 2'(k);
      #1 check("oe", 16'(result_bus_oe_out), 16'(k == 0));
    end
    for (int j = 0; j < 2; j++) begin
      @(negedge clock_in) select_n_in = j[0];
      @(negedge clock_in) power_down_n_in = 0;
      repeat (3) @(negedge clock_in);
      check("shutdown", 16'({nap_out, sleep_out}), 16'(j ? 1 : 2));
      power_down_n_in = 1;
      // host-side settling wait before any further start
      repeat (15) @(negedge clock_in);
    end
    test_done();
  end
endmodule : sacc_bench

bind sacc_top sacc_monitor #(.WIDTH(WIDTH)) MON (.clock_in, .reset_in, .select_n_in,
  .convert_start_n_in, .read_n_in, .power_down_n_in, .result_bus_out, .result_bus_oe_out,
  .busy_out, .approximation_register_out, .nap_out, .sleep_out, .stream_valid_out);

// File: tb/sacc_host.sv
// host-side result sink that can stall
`timescale 1ns/10ps
module sacc_host
  import sacc_pkg::*;
(
  // clock and stall control
  input wire logic clock_in,
  input wire logic stall_in,
  // result stream
  input wire logic stream_valid_in,
  input wire logic [SACC_WIDTH-1:0] stream_data_in,
  output logic stream_ready_out
);
  //==========
  // captured words, oldest first
  logic [SACC_WIDTH-1:0] got_q[$];
  assign stream_ready_out = !stall_in;
  always @(posedge clock_in) begin
    if (stream_valid_in && stream_ready_out) got_q.push_back(stream_data_in);
  end
endmodule : sacc_host

// File: tb/sacc_monitor.sv
// port checker for the sar conversion control block
`timescale 1ns/10ps
module sacc_monitor #(
  parameter int WIDTH = 16
) (
  // pins from the host
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic select_n_in,
  input wire logic convert_start_n_in,
  input wire logic read_n_in,
  input wire logic power_down_n_in,
  // block outputs
  input wire logic [WIDTH-1:0] result_bus_out,
  input wire logic result_bus_oe_out,
  input wire logic busy_out,
  input wire logic [WIDTH-1:0] approximation_register_out,
  input wire logic nap_out,
  input wire logic sleep_out,
  input wire logic stream_valid_out
);
  //==========
  // properties, one clock domain
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_start_cause:
    assert property ($fell(busy_out) |-> $past(!select_n_in && !convert_start_n_in)
      && $past(convert_start_n_in, 2)) else $error("busy fell without a start edge");
  a_busy_span:
    assert property ($fell(busy_out) |-> ##63 !busy_out ##1 busy_out)
      else $error("conversion length wrong");
  a_sar_clear:
    assert property ($fell(busy_out) |-> approximation_register_out == {1'b1, {(WIDTH-1){1'b0}}})
      else $error("word not cleared at start");
  a_msb_first:
    assert property ($fell(busy_out) |-> ##4
      approximation_register_out[WIDTH-2:0] == {1'b1, {(WIDTH-2){1'b0}}})
      else $error("second trial bit wrong");
  a_oe_gate:
    assert property (result_bus_oe_out == (!read_n_in && !select_n_in))
      else $error("output enable wrong");
  a_result_hold:
    assert property (!busy_out |-> $stable(result_bus_out)) else $error("result moved");
  a_load_push:
    assert property ($rose(busy_out) |-> ##1 stream_valid_out) else $error("no push");
  a_nap_entry:
    assert property ($fell(power_down_n_in) && !select_n_in |-> ##[1:2] nap_out && !sleep_out)
      else $error("nap not entered");
  a_sleep_entry:
    assert property ($fell(power_down_n_in) && select_n_in |-> ##[1:2] sleep_out && !nap_out)
      else $error("sleep not entered");
  // main scenarios reached
  c_done: cover property ($rose(busy_out));
  c_nap: cover property (nap_out);
  c_sleep: cover property (sleep_out);
endmodule : sacc_monitor
